// ---- common/spi_frontend_pkg.sv ----
// constants, codes and state types shared by both ends of the mode-register link
// assumes a 100 MHz system clock on each end
package spi_frontend_pkg;
   localparam int FRAME_BITS = 16;
   localparam int DATA_BITS = 12;
   localparam logic [4:0] FRAME_COUNT = 5'h10;
   localparam logic [4:0] HEADER_COUNT = 5'h04;
   localparam logic [4:0] COUNT_MAX = 5'h1F;
   // frame fields
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 14;
   localparam int FB_SEL_BIT = 13;
   localparam int RO_BIT = 12;
   // same fields counted within the four header bits
   localparam int HDR_ADDR_MSB = ADDR_MSB - DATA_BITS;
   localparam int HDR_ADDR_LSB = ADDR_LSB - DATA_BITS;
   localparam int HDR_FB_SEL_BIT = FB_SEL_BIT - DATA_BITS;
   localparam logic [1:0] ADDR_MODE = 2'h0;
   localparam logic [1:0] ADDR_INT = 2'h1;
   localparam logic [1:0] ADDR_SETUP = 2'h2;
   localparam logic [1:0] ADDR_XCVR = 2'h3;
   // mode register fields
   localparam int WD_MSB = 11;
   localparam int WD_LSB = 6;
   localparam int STATE_MSB = 5;
   localparam int STATE_LSB = 3;
   localparam int DEBUG_BIT = 2;
   localparam int ENABLE_BIT = 1;
   localparam logic [2:0] OM_NONE = 3'h0;
   localparam logic [2:0] OM_NORMAL = 3'h1;
   localparam logic [2:0] OM_STANDBY = 3'h2;
   localparam logic [2:0] OM_INIT_FLASH = 3'h3;
   localparam logic [2:0] OM_SLEEP = 3'h4;
   localparam logic [2:0] OM_INIT_NORMAL = 3'h5;
   localparam logic [2:0] OM_LEAVE_FLASH = 3'h6;
   localparam logic [2:0] OM_FLASH = 3'h7;
   localparam logic [1:0] SEQ_IDLE = 2'h0;
   localparam logic [1:0] SEQ_FLASH1 = 2'h1;
   localparam logic [1:0] SEQ_NORMAL2 = 2'h2;
   // interrupt flag and enable positions
   localparam int FLAG_OVERTEMP = 0;
   localparam int FLAG_SPI_FAIL = 1;
   localparam int FLAG_W = 2;
   // status readback: live over-temperature bit above the reset cause
   localparam int STATUS_OT_BIT = 4;
   localparam int STATUS_CAUSE_MSB = 3;
   localparam int PRESCALE_MSB = 1;
   localparam int PRESCALE_LSB = 0;
   localparam logic [3:0] CAUSE_POWER_ON = 4'h0;
   localparam logic [3:0] CAUSE_SPI_CLOCK = 4'h1;
   localparam logic [3:0] CAUSE_ILLEGAL = 4'h2;
   localparam logic [3:0] CAUSE_FORBIDDEN = 4'h3;
   localparam logic [3:0] CAUSE_FLASH_ENTRY = 4'h4;
   localparam logic [3:0] CAUSE_LEAVE_FLASH = 4'h5;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESET_PULSE_NS = 1000;
   localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCK_HALF_NS = 80;
   localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      SYS_STARTUP = 3'h0,
      SYS_NORMAL = 3'h1,
      SYS_STANDBY = 3'h3,
      SYS_SLEEP = 3'h2,
      SYS_FLASH = 3'h6,
      SYS_RESTART = 3'h7
   } sys_state_e;

   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_LEAD = 3'h1,
      H_HIGH = 3'h3,
      H_LOW = 3'h2,
      H_TRAIL = 3'h6,
      H_GAP = 3'h7
   } host_state_e;

   function automatic logic period_code_ok(input logic [5:0] code);
      case (code)
         6'h09, 6'h0C, 6'h12, 6'h14, 6'h1B, 6'h24, 6'h2D, 6'h33, 6'h35, 6'h36: period_code_ok = 1'b1;
         default: period_code_ok = 1'b0;
      endcase
   endfunction
endpackage

// ---- common/spi_link_if.sv ----
// four-wire serial link between the host and the mode-register front end
// the data-out wire reads low while the device does not drive it (weak pull-down)
`timescale 1ns/10ps
interface spi_link_if;
   logic sck;
   logic cs_n;
   logic sdi;
   logic sdo_out;
   logic sdo_oe_n;
   logic sdo_level;

   assign sdo_level = sdo_oe_n ? 1'b0 : sdo_out;

   modport device (input sck, input cs_n, input sdi, output sdo_out, output sdo_oe_n);
   modport host (output sck, output cs_n, output sdi, input sdo_level);
endinterface

// ---- src/spi_mode_register_frontend.sv ----
// device end: frame shifting, clock-count check, header decode, mode register
// assumes link pins are asynchronous to i_clk; status inputs are on i_clk
`timescale 1ns/10ps
module spi_mode_register_frontend
   import spi_frontend_pkg::*;
#(
   parameter int RESET_CYCLES = RESET_PULSE_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_system_reset_n,
   spi_link_if.device link,
   input wire logic i_core_supply_on,
   input wire logic i_overtemp,
   input wire logic [11:0] i_system_status,
   input wire logic [11:0] i_system_diagnosis,
   output logic o_system_reset_n,
   output logic o_enable,
   output logic o_debug_relax,
   output logic [5:0] o_watchdog_period_code,
   output logic [1:0] o_watchdog_prescale,
   output logic o_watchdog_retrigger,
   output sys_state_e o_system_state,
   output logic [3:0] o_reset_cause,
   output logic o_interrupt,
   output logic [11:0] o_interrupt_enable,
   output logic [11:0] o_system_setup,
   output logic [11:0] o_transceiver_control
);
   localparam int RST_W = $clog2(RESET_CYCLES + 1);

   typedef struct packed {
      logic [1:0] sck_s;
      logic [1:0] cs_s;
      logic [1:0] sdi_s;
      logic sck_d;
      logic cs_d;
      logic ot_d;
      logic [4:0] bit_cnt;
      logic [15:0] rx;
      logic [11:0] fb;
      logic sdo;
      logic [11:0] mode;
      logic [11:0] int_en;
      logic [11:0] special;
      logic [11:0] setup;
      logic [11:0] xcvr;
      logic [11:0] scratch0;
      logic [11:0] scratch1;
      logic [FLAG_W-1:0] flags;
      sys_state_e state;
      logic [1:0] flash_seq;
      logic flash_armed;
      logic [3:0] cause;
      logic [RST_W-1:0] rst_cnt;
      logic retrigger;
   } dev_state_s;

   dev_state_s r;
   dev_state_s n;

   always_comb begin
      logic sck_rise;
      logic sck_fall;
      logic cs_fall;
      logic cs_rise;
      logic setup_mode;
      logic normal_group;
      logic [3:0] hdr;
      logic [2:0] om;
      logic ok;
      logic force_rst;
      logic [3:0] rst_cause;
      sys_state_e rst_state;
      sys_state_e next_st;
      logic [FLAG_W-1:0] set_f;
      logic [FLAG_W-1:0] clr_f;
      logic [11:0] status_rb;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      cs_fall = 1'b0;
      cs_rise = 1'b0;
      setup_mode = 1'b0;
      normal_group = 1'b0;
      hdr = '0;
      om = OM_NONE;
      ok = 1'b0;
      force_rst = 1'b0;
      rst_cause = CAUSE_POWER_ON;
      rst_state = SYS_RESTART;
      next_st = SYS_STARTUP;
      set_f = '0;
      clr_f = '0;
      status_rb = '0;
      n = r;
      n.retrigger = 1'b0;
      n.sck_s = {r.sck_s[0], link.sck};
      n.cs_s = {r.cs_s[0], link.cs_n};
      n.sdi_s = {r.sdi_s[0], link.sdi};
      n.sck_d = r.sck_s[1];
      n.cs_d = r.cs_s[1];
      n.ot_d = i_overtemp;
      sck_rise = r.sck_s[1] & ~r.sck_d;
      sck_fall = ~r.sck_s[1] & r.sck_d;
      cs_fall = ~r.cs_s[1] & r.cs_d;
      cs_rise = r.cs_s[1] & ~r.cs_d;
      setup_mode = (r.state == SYS_STARTUP) || (r.state == SYS_RESTART);
      normal_group = (r.state == SYS_NORMAL) || (r.state == SYS_STANDBY);
      if (r.rst_cnt != '0) begin
         n.rst_cnt = r.rst_cnt - 1'b1;
      end
      // status only; shutting anything down is left to the host
      status_rb = i_system_status;
      status_rb[STATUS_OT_BIT] = i_overtemp & i_core_supply_on;
      status_rb[STATUS_CAUSE_MSB:0] = r.cause;
      if (i_overtemp && !r.ot_d && i_core_supply_on && r.int_en[FLAG_OVERTEMP]) begin
         set_f[FLAG_OVERTEMP] = 1'b1;
      end
      if (cs_fall) begin
         n.bit_cnt = '0;
         n.sdo = 1'b0;
         n.fb = '0;
      end else if (!r.cs_s[1]) begin
         if (sck_fall) begin
            n.rx = {r.rx[FRAME_BITS-2:0], r.sdi_s[1]};
            if (r.bit_cnt != COUNT_MAX) begin
               n.bit_cnt = r.bit_cnt + 1'b1;
            end
            if (n.bit_cnt == HEADER_COUNT && r.bit_cnt != HEADER_COUNT) begin
               hdr = n.rx[3:0];
               unique case (hdr[HDR_ADDR_MSB:HDR_ADDR_LSB])
                  ADDR_MODE: n.fb = hdr[HDR_FB_SEL_BIT] ? i_system_diagnosis : status_rb;
                  ADDR_INT: begin
                     if (!hdr[HDR_FB_SEL_BIT]) begin
                        n.fb = r.int_en;
                     end else if (setup_mode) begin
                        n.fb = r.special;
                     end else begin
                        n.fb = {{(DATA_BITS-FLAG_W){1'b0}}, r.flags};
                        clr_f = '1;
                     end
                  end
                  ADDR_SETUP: n.fb = hdr[HDR_FB_SEL_BIT] ? r.scratch0 : r.setup;
                  ADDR_XCVR: n.fb = hdr[HDR_FB_SEL_BIT] ? r.scratch1 : r.xcvr;
               endcase
            end else if (r.bit_cnt >= HEADER_COUNT) begin
               n.fb = {r.fb[DATA_BITS-2:0], 1'b0};
            end
         end else if (sck_rise) begin
            n.sdo = (r.bit_cnt >= HEADER_COUNT && r.bit_cnt < FRAME_COUNT) ? r.fb[DATA_BITS-1] : 1'b0;
         end
      end
      if (cs_rise) begin
         if (r.bit_cnt != FRAME_COUNT) begin
            // frame dropped whole, except a flag read-clear already made at the header
            if (setup_mode) begin
               force_rst = 1'b1;
               rst_cause = CAUSE_SPI_CLOCK;
            end else if (r.int_en[FLAG_SPI_FAIL]) begin
               set_f[FLAG_SPI_FAIL] = 1'b1;
            end
         end else if (!r.rx[RO_BIT]) begin
            unique case (r.rx[ADDR_MSB:ADDR_LSB])
               ADDR_MODE: begin
                  om = r.rx[STATE_MSB:STATE_LSB];
                  if (om == OM_NONE || !period_code_ok(r.rx[WD_MSB:WD_LSB])) begin
                     force_rst = 1'b1;
                     rst_cause = CAUSE_ILLEGAL;
                  end else begin
                     ok = 1'b1;
                     next_st = r.state;
                     n.flash_seq = SEQ_IDLE;
                     case (r.state)
                        SYS_STARTUP, SYS_RESTART: begin
                           n.flash_armed = 1'b0;
                           if (om == OM_INIT_NORMAL) begin
                              next_st = SYS_NORMAL;
                           end else if (om == OM_INIT_FLASH && r.flash_armed) begin
                              next_st = SYS_FLASH;
                           end else begin
                              ok = 1'b0;
                           end
                        end
                        SYS_NORMAL: begin
                           if (om == OM_NORMAL) begin
                              n.flash_seq = (r.flash_seq == SEQ_FLASH1) ? SEQ_NORMAL2 : SEQ_IDLE;
                           end else if (om == OM_FLASH) begin
                              if (r.flash_seq == SEQ_NORMAL2) begin
                                 force_rst = 1'b1;
                                 rst_cause = CAUSE_FLASH_ENTRY;
                                 rst_state = SYS_STARTUP;
                                 n.flash_armed = 1'b1;
                              end else begin
                                 n.flash_seq = SEQ_FLASH1;
                              end
                           end else if (om == OM_STANDBY) begin
                              next_st = SYS_STANDBY;
                           end else if (om == OM_SLEEP) begin
                              next_st = SYS_SLEEP;
                           end else begin
                              ok = 1'b0;
                           end
                        end
                        SYS_STANDBY: begin
                           if (om == OM_NORMAL) begin
                              next_st = SYS_NORMAL;
                           end else if (om == OM_SLEEP) begin
                              next_st = SYS_SLEEP;
                           end else if (om != OM_STANDBY) begin
                              ok = 1'b0;
                           end
                        end
                        SYS_FLASH: begin
                           if (om == OM_LEAVE_FLASH) begin
                              force_rst = 1'b1;
                              rst_cause = CAUSE_LEAVE_FLASH;
                              rst_state = SYS_STARTUP;
                           end else if (om != OM_FLASH) begin
                              ok = 1'b0;
                           end
                        end
                        default: ok = 1'b0;
                     endcase
                     if (!ok) begin
                        force_rst = 1'b1;
                        rst_cause = CAUSE_FORBIDDEN;
                        rst_state = SYS_RESTART;
                        n.flash_armed = r.flash_armed;
                     end else begin
                        n.mode = r.rx[DATA_BITS-1:0];
                        n.retrigger = 1'b1;
                        n.state = next_st;
                     end
                  end
               end
               ADDR_INT: begin
                  if (setup_mode) begin
                     n.special = r.rx[DATA_BITS-1:0];
                  end else if (r.state != SYS_SLEEP) begin
                     n.int_en = r.rx[DATA_BITS-1:0];
                  end
               end
               ADDR_SETUP: begin
                  if (normal_group) begin
                     n.setup = r.rx[DATA_BITS-1:0];
                  end else if (r.state != SYS_SLEEP) begin
                     n.scratch0 = r.rx[DATA_BITS-1:0];
                  end
               end
               ADDR_XCVR: begin
                  if (normal_group) begin
                     n.xcvr = r.rx[DATA_BITS-1:0];
                  end else if (r.state != SYS_SLEEP) begin
                     n.scratch1 = r.rx[DATA_BITS-1:0];
                  end
               end
            endcase
         end
      end
      // a new event beats a read clear; a system reset clears all flags
      n.flags = (r.flags & ~clr_f) | set_f;
      if (force_rst) begin
         n.rst_cnt = RST_W'(RESET_CYCLES);
         n.cause = rst_cause;
         n.state = rst_state;
         n.flash_seq = SEQ_IDLE;
      end
      if (force_rst || r.rst_cnt != '0) begin
         n.flags = '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_system_reset_n) begin
      if (!i_system_reset_n) begin
         r <= '0;
         r.cs_s <= '1;
         r.cs_d <= 1'b1;
         r.state <= SYS_STARTUP;
      end else begin
         r <= n;
      end
   end

   assign link.sdo_out = r.sdo;
   assign link.sdo_oe_n = r.cs_s[1];
   assign o_system_reset_n = (r.rst_cnt == '0);
   assign o_enable = r.mode[ENABLE_BIT];
   assign o_debug_relax = r.mode[DEBUG_BIT];
   assign o_watchdog_period_code = r.mode[WD_MSB:WD_LSB];
   assign o_watchdog_prescale = r.special[PRESCALE_MSB:PRESCALE_LSB];
   assign o_watchdog_retrigger = r.retrigger;
   assign o_system_state = r.state;
   assign o_reset_cause = r.cause;
   assign o_interrupt = |r.flags;
   assign o_interrupt_enable = r.int_en;
   assign o_system_setup = r.setup;
   assign o_transceiver_control = r.xcvr;
endmodule

// ---- src/spi_mode_register_host.sv ----
// host end: sends one 16-bit frame per request with i_clock_count clocks and returns the word shifted back
// assumes the device answer arrives asynchronously; the serial clock is made here
`timescale 1ns/10ps
module spi_mode_register_host
   import spi_frontend_pkg::*;
#(
   parameter int HALF_CYCLES = SCK_HALF_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_system_reset_n,
   spi_link_if.host link,
   input wire logic i_start,
   input wire logic [15:0] i_frame,
   input wire logic [4:0] i_clock_count,
   output logic o_busy,
   output logic o_done,
   output logic [15:0] o_rx_frame
);
   localparam int TW = $clog2(HALF_CYCLES + 1);
   localparam logic [TW-1:0] HALF_LOAD = TW'(HALF_CYCLES - 1);

   typedef struct packed {
      host_state_e state;
      logic cs_n;
      logic sck;
      logic sdi;
      logic [15:0] tx;
      logic [15:0] rx;
      logic [15:0] rx_out;
      logic [4:0] cnt;
      logic [4:0] target;
      logic [TW-1:0] timer;
      logic done;
      logic [1:0] sdo_s;
   } host_state_s;

   host_state_s r;
   host_state_s n;

   always_comb begin
      n = r;
      n.done = 1'b0;
      n.sdo_s = {r.sdo_s[0], link.sdo_level};
      if (r.timer != '0) begin
         n.timer = r.timer - 1'b1;
      end
      unique case (r.state)
         H_IDLE: begin
            if (i_start) begin
               // frames go out verbatim: cyclic mode writes and the flash sequence come from the user
               n.tx = i_frame;
               n.target = i_clock_count;
               n.cnt = '0;
               n.cs_n = 1'b0;
               n.sdi = i_frame[FRAME_BITS-1];
               n.timer = HALF_LOAD;
               n.state = H_LEAD;
            end
         end
         H_LEAD: begin
            if (r.timer == '0) begin
               n.timer = HALF_LOAD;
               if (r.target == '0) begin
                  n.state = H_TRAIL;
               end else begin
                  n.sck = 1'b1;
                  n.sdi = r.tx[FRAME_BITS-1];
                  n.state = H_HIGH;
               end
            end
         end
         H_HIGH: begin
            if (r.timer == '0) begin
               n.sck = 1'b0;
               n.rx = {r.rx[FRAME_BITS-2:0], r.sdo_s[1]};
               n.tx = {r.tx[FRAME_BITS-2:0], 1'b0};
               n.cnt = r.cnt + 1'b1;
               n.timer = HALF_LOAD;
               n.state = (n.cnt == r.target) ? H_TRAIL : H_LOW;
            end
         end
         H_LOW: begin
            if (r.timer == '0) begin
               n.sck = 1'b1;
               n.sdi = r.tx[FRAME_BITS-1];
               n.timer = HALF_LOAD;
               n.state = H_HIGH;
            end
         end
         H_TRAIL: begin
            if (r.timer == '0) begin
               n.cs_n = 1'b1;
               n.sdi = 1'b0;
               n.timer = HALF_LOAD;
               n.state = H_GAP;
            end
         end
         H_GAP: begin
            if (r.timer == '0) begin
               n.done = 1'b1;
               n.rx_out = r.rx;
               n.state = H_IDLE;
            end
         end
         default: n.state = H_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_system_reset_n) begin
      if (!i_system_reset_n) begin
         r <= '0;
         r.cs_n <= 1'b1;
         r.state <= H_IDLE;
      end else begin
         r <= n;
      end
   end

   assign link.cs_n = r.cs_n;
   assign link.sck = r.sck;
   assign link.sdi = r.sdi;
   assign o_busy = (r.state != H_IDLE);
   assign o_done = r.done;
   assign o_rx_frame = r.rx_out;
endmodule

// ---- bench/spi_link_properties.sv ----
// wire-level checks on the link joining the host end and the device end
// assumes all signals are sampled on the shared system clock, reset active low
`timescale 1ns/10ps
module spi_link_properties (
   input wire logic i_clk,
   input wire logic i_system_reset_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo_out,
   input wire logic sdo_oe_n
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_system_reset_n);
   // two sync stages and no further flop sit between cs_n and the enable
   property p_float; cs_n [*5] |-> sdo_oe_n; endproperty
   a_float: assert property (p_float) else $error("data out driven while deselected");
   property p_drive; !cs_n [*5] |-> !sdo_oe_n; endproperty
   a_drive: assert property (p_drive) else $error("data out not driven in frame");
   property p_idle; cs_n && $past(cs_n) |-> !sck; endproperty
   a_idle: assert property (p_idle) else $error("serial clock not idle low");
   property p_sdi; $changed(sdi) && !cs_n && !$past(cs_n) |-> $rose(sck); endproperty
   a_sdi: assert property (p_sdi) else $error("data in moved off a rising edge");
   property p_high; $rose(sck) |-> sck [*4]; endproperty
   a_high: assert property (p_high) else $error("serial clock high phase short");
   property p_low; $fell(sck) |-> !sck [*4]; endproperty
   a_low: assert property (p_low) else $error("serial clock low phase short");
   property p_gap; $rose(cs_n) |-> cs_n [*4]; endproperty
   a_gap: assert property (p_gap) else $error("chip select gap short");
   // data out may only move in the high phase that follows a rise
   property p_sdo; $changed(sdo_out) && !cs_n && !$past(cs_n, 6) |-> sck && $past(sck); endproperty
   a_sdo: assert property (p_sdo) else $error("data out moved outside high phase");
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench: host end and device end joined by the link interface
// assumes 100 MHz clock; device reset pulse shortened to four cycles
`timescale 1ns/10ps
module tb_top;
   import spi_frontend_pkg::*;
   localparam int RST_CYC = 4;
   localparam logic [15:0] NOCHK = 16'hffff;
   typedef struct packed {
      logic [15:0] f;
      logic [4:0] n;
      logic [15:0] rx;
      sys_state_e st;
      logic [3:0] c;
      logic r;
      logic q;
   } row_s;
   row_s rows [32] = '{
      '{16'h026a,5'h10,16'h0a00,SYS_NORMAL,4'h0,1'h0,1'h0}, '{16'h3000,5'h10,16'h05a5,SYS_NORMAL,4'h0,1'h0,1'h0},
      '{16'h4003,5'h10,16'h0000,SYS_NORMAL,4'h0,1'h0,1'h0}, '{16'h5000,5'h10,16'h0003,SYS_NORMAL,4'h0,1'h0,1'h0},
      '{16'h8abc,5'h10,16'h0000,SYS_NORMAL,4'h0,1'h0,1'h0}, '{16'h9000,5'h10,16'h0abc,SYS_NORMAL,4'h0,1'h0,1'h0},
      '{16'hc123,5'h10,16'h0000,SYS_NORMAL,4'h0,1'h0,1'h0}, '{16'hd000,5'h10,16'h0123,SYS_NORMAL,4'h0,1'h0,1'h0},
      '{16'h8fff,5'h0f,NOCHK,SYS_NORMAL,4'h0,1'h0,1'h1}, '{16'h9000,5'h10,16'h0abc,SYS_NORMAL,4'h0,1'h0,1'h1},
      '{16'h7000,5'h10,16'h0002,SYS_NORMAL,4'h0,1'h0,1'h0}, '{16'h024a,5'h10,16'h0a00,SYS_NORMAL,4'h0,1'h0,1'h0},
      '{16'h027a,5'h10,16'h0a00,SYS_NORMAL,4'h0,1'h0,1'h0}, '{16'h024a,5'h10,16'h0a00,SYS_NORMAL,4'h0,1'h0,1'h0},
      '{16'h027a,5'h10,16'h0a00,SYS_STARTUP,4'h4,1'h1,1'h0}, '{16'h1000,5'h10,16'h0a04,SYS_STARTUP,4'h4,1'h0,1'h0},
      '{16'h025a,5'h10,16'h0a04,SYS_FLASH,4'h4,1'h0,1'h0}, '{16'h0272,5'h10,16'h0a04,SYS_STARTUP,4'h5,1'h1,1'h0},
      '{16'h026a,5'h10,16'h0a05,SYS_NORMAL,4'h5,1'h0,1'h0}, '{16'h026a,5'h10,16'h0a05,SYS_RESTART,4'h3,1'h1,1'h0},
      '{16'h0000,5'h11,NOCHK,SYS_RESTART,4'h1,1'h1,1'h0}, '{16'h002a,5'h10,16'h0a01,SYS_RESTART,4'h2,1'h1,1'h0},
      '{16'h0242,5'h10,16'h0a02,SYS_RESTART,4'h2,1'h1,1'h0}, '{16'h4001,5'h10,16'h0003,SYS_RESTART,4'h2,1'h0,1'h0},
      '{16'h7000,5'h10,16'h0001,SYS_RESTART,4'h2,1'h0,1'h0}, '{16'h8555,5'h10,16'h0abc,SYS_RESTART,4'h2,1'h0,1'h0},
      '{16'hb000,5'h10,16'h0555,SYS_RESTART,4'h2,1'h0,1'h0}, '{16'h026c,5'h10,16'h0a02,SYS_NORMAL,4'h2,1'h0,1'h0},
      '{16'h0254,5'h10,16'h0a02,SYS_STANDBY,4'h2,1'h0,1'h0}, '{16'h0264,5'h10,16'h0a02,SYS_SLEEP,4'h2,1'h0,1'h0},
      '{16'h0264,5'h10,16'h0a02,SYS_RESTART,4'h3,1'h1,1'h0}, '{16'h026c,5'h10,16'h0a03,SYS_NORMAL,4'h3,1'h0,1'h0}};
   logic i_clk = 1'h0;
   logic i_system_reset_n = 1'h0;
   logic start = 1'h0;
   logic ot = 1'h0;
   logic sup = 1'h1;
   logic [15:0] frame = 16'h0000;
   logic [4:0] count = 5'h00;
   logic busy, done, rst_n, en, dbg, retrig, irq;
   logic [15:0] rx;
   logic [5:0] wdp;
   logic [1:0] pre;
   logic [3:0] cause;
   logic [11:0] ien, setup, xcvr;
   sys_state_e st;
   int n_errors = 0;
   int checks = 0;
   int lows = 0;
   int trigs = 0;
   spi_link_if spi_link_if_i ();
   spi_mode_register_frontend #(.RESET_CYCLES(RST_CYC)) spi_mode_register_frontend_i (.i_clk(i_clk), .i_system_reset_n(i_system_reset_n),
      .link(spi_link_if_i), .i_core_supply_on(sup), .i_overtemp(ot), .i_system_status(12'ha00),
      .i_system_diagnosis(12'h5a5), .o_system_reset_n(rst_n), .o_enable(en), .o_debug_relax(dbg),
      .o_watchdog_period_code(wdp), .o_watchdog_prescale(pre), .o_watchdog_retrigger(retrig), .o_system_state(st),
      .o_reset_cause(cause), .o_interrupt(irq), .o_interrupt_enable(ien), .o_system_setup(setup),
      .o_transceiver_control(xcvr));
   spi_mode_register_host spi_mode_register_host_i (.i_clk(i_clk), .i_system_reset_n(i_system_reset_n), .link(spi_link_if_i),
      .i_start(start), .i_frame(frame), .i_clock_count(count), .o_busy(busy), .o_done(done), .o_rx_frame(rx));
   spi_link_properties spi_link_properties_i (.i_clk(i_clk), .i_system_reset_n(i_system_reset_n), .sck(spi_link_if_i.sck),
      .cs_n(spi_link_if_i.cs_n), .sdi(spi_link_if_i.sdi), .sdo_out(spi_link_if_i.sdo_out),
      .sdo_oe_n(spi_link_if_i.sdo_oe_n));
   initial begin
      forever #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
   end
   // counted mid-cycle, away from the edge that launches these outputs
   always @(negedge i_clk) begin
      if (rst_n === 1'h0) lows++;
      if (retrig === 1'h1) trigs++;
   end
   task automatic summarize();
      $display("n_errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_st(input sys_state_e got, input sys_state_e exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t state got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [15:0] f, input logic [4:0] n);
      int k;
      @(negedge i_clk);
      frame = f;
      count = n;
      start = 1'h1;
      lows = 0;
      trigs = 0;
      @(negedge i_clk);
      start = 1'h0;
      chk({15'h0000, busy}, 16'h0001, "busy");
      for (k = 0; k < 2000 && done !== 1'h1; k++) @(negedge i_clk);
      if (k == 2000) begin
         n_errors++;
         $display("CHECK FAILED %0t no done", $time);
         summarize();
      end
      // frame effects land a few clocks after chip select rises
      repeat (12) @(negedge i_clk);
   endtask
   initial begin
      repeat (8) @(negedge i_clk);
      i_system_reset_n = 1'h1;
      foreach (rows[k]) begin
         send(rows[k].f, rows[k].n);
         if (rows[k].rx !== NOCHK) chk(rx, rows[k].rx, "readback");
         chk_st(st, rows[k].st);
         chk({12'h000, cause}, {12'h000, rows[k].c}, "cause");
         chk(16'(lows), rows[k].r ? 16'(RST_CYC) : 16'h0000, "reset pulse");
         chk({15'h0000, irq}, {15'h0000, rows[k].q}, "interrupt");
      end
      chk({15'h0000, en}, 16'h0000, "enable");
      chk({15'h0000, dbg}, 16'h0001, "debug");
      chk({10'h000, wdp}, 16'h0009, "period");
      chk({14'h0000, pre}, 16'h0001, "prescale");
      chk({4'h0, setup}, 16'h0abc, "setup");
      chk({4'h0, xcvr}, 16'h0123, "transceiver");
      send(16'h024c, 5'h10);
      chk(16'(trigs), 16'h0001, "retrigger");
      send(16'h4001, 5'h10);
      chk({4'h0, ien}, 16'h0001, "enables");
      // no flag while the core supply is off
      sup = 1'h0;
      ot = 1'h1;
      repeat (4) @(negedge i_clk);
      chk({15'h0000, irq}, 16'h0000, "overtemp unpowered");
      ot = 1'h0;
      sup = 1'h1;
      @(negedge i_clk);
      ot = 1'h1;
      repeat (4) @(negedge i_clk);
      chk({15'h0000, irq}, 16'h0001, "overtemp");
      send(16'h1000, 5'h10);
      chk(rx, 16'h0a13, "status");
      chk_st(st, SYS_NORMAL);
      i_system_reset_n = 1'h0;
      @(negedge i_clk);
      chk_st(st, SYS_STARTUP);
      chk({4'h0, ien}, 16'h0000, "enables cleared");
      chk({15'h0000, rst_n}, 16'h0001, "reset out high");
      chk({15'h0000, spi_link_if_i.sdo_oe_n}, 16'h0001, "float");
      repeat (2) @(negedge i_clk);
      i_system_reset_n = 1'h1;
      send(16'h1000, 5'h10);
      chk(rx, 16'h0a10, "status after reset");
      summarize();
   end
endmodule
